// File: irqc_top.v
`timescale 1ns/10ps
`include "irqc_consts.vh"

module irqc_top #(
    parameter NSRC = `IRQC_NSRC
) (
    // clock, reset, enable
    input  wire            ref_clk,
    input  wire            rst_n,
    input  wire            ce,

    // byte access to registers
    input  wire [7:0]      sfr_addr,
    input  wire            sfr_wr,
    input  wire            sfr_rd,
    input  wire [7:0]      sfr_wdata,
    output reg  [7:0]      sfr_rdata,

    // bit access to registers
    input  wire [7:0]      bit_addr,
    input  wire            bit_wr,
    input  wire            bit_rd,
    input  wire            bit_wdata,
    output reg             bit_rdata,

    // pending conditions, polling order
    input  wire [NSRC-1:0] src_pend,

    // core status
    input  wire            core_off_mode,
    input  wire            insn_done,
    input  wire            reti,
    input  wire            irq_ack,

    // dispatch
    output reg             irq_req,
    output reg  [15:0]     irq_vector,
    output reg  [3:0]      irq_src,
    output reg  [2:0]      irq_active
);
    // register contents
    wire [7:0] en_reg;
    wire [7:0] en2_reg;
    wire [7:0] lvl_reg;
    wire [7:0] wdog_reg;

    // decode
    wire       en_byte_we;
    wire       en2_byte_we;
    wire       lvl_byte_we;
    wire       wdog_byte_we;
    wire       en_bit_hit;
    wire       lvl_bit_hit;
    wire       wdog_bit_hit;
    wire       cfg_access;

    // request shaping
    wire [NSRC-1:0] src_enable;
    wire [NSRC-1:0] src_high;
    wire [NSRC-1:0] req_all;
    wire [NSRC-1:0] req_lvl [0:2];
    wire [2:0]      lvl_found;
    wire [3:0]      lvl_idx [0:2];

    // dispatch state
    reg  [2:0]  active_q;
    reg  [2:0]  active_d;
    reg         hold_q;
    reg         hold_d;
    reg         req_q;
    reg         req_d;
    reg  [1:0]  lvl_q;
    reg  [1:0]  lvl_d;
    reg  [3:0]  idx_q;
    reg  [3:0]  idx_d;
    reg  [15:0] vec_q;
    reg  [15:0] vec_d;
    reg  [7:0]  rdata_d;
    reg         bdata_d;
    reg         pick_ok;
    reg  [1:0]  pick_lvl;
    reg  [3:0]  pick_idx;

    // bit address falls inside the byte at base
    function bit_in;
        input [7:0] a;
        input [7:0] base;
        begin
            bit_in = (a[7:3] == base[7:3]);
        end
    endfunction

    // fixed vector of a source
    function [15:0] vec_of;
        input [3:0] s;
        begin
            case (s)
                `IRQC_SRC_EXT0:  vec_of = 16'h0003;
                `IRQC_SRC_T0:    vec_of = 16'h000b;
                `IRQC_SRC_EXT1:  vec_of = 16'h0013;
                `IRQC_SRC_T1:    vec_of = 16'h001b;
                `IRQC_SRC_UART:  vec_of = 16'h0023;
                `IRQC_SRC_T2:    vec_of = 16'h002b;
                `IRQC_SRC_TEMP:  vec_of = 16'h0033;
                `IRQC_SRC_SPI:   vec_of = 16'h003b;
                `IRQC_SRC_PSM:   vec_of = 16'h0043;
                `IRQC_SRC_METER: vec_of = 16'h004b;
                `IRQC_SRC_RTC:   vec_of = 16'h0053;
                `IRQC_SRC_WDT:   vec_of = 16'h005b;
                `IRQC_SRC_UART2: vec_of = 16'h0063;
                default:         vec_of = `IRQC_VEC_BASE;
            endcase
        end
    endfunction

    // byte decode
    assign en_byte_we   = sfr_wr && (sfr_addr == `IRQC_ADDR_EN);
    assign en2_byte_we  = sfr_wr && (sfr_addr == `IRQC_ADDR_EN2);
    assign lvl_byte_we  = sfr_wr && (sfr_addr == `IRQC_ADDR_LVL);
    assign wdog_byte_we = sfr_wr && (sfr_addr == `IRQC_ADDR_WDOG);

    // bit decode; the second register has no bit addresses
    assign en_bit_hit   = bit_in(bit_addr, `IRQC_ADDR_EN);
    assign lvl_bit_hit  = bit_in(bit_addr, `IRQC_ADDR_LVL);
    assign wdog_bit_hit = bit_in(bit_addr, `IRQC_ADDR_WDOG);

    // any touch of enable or level registers
    assign cfg_access =
        ((sfr_wr || sfr_rd) &&
         ((sfr_addr == `IRQC_ADDR_EN) ||
          (sfr_addr == `IRQC_ADDR_EN2) ||
          (sfr_addr == `IRQC_ADDR_LVL))) ||
        ((bit_wr || bit_rd) && (en_bit_hit || lvl_bit_hit));

    irqc_sfr8 #(
        .RST    (`IRQC_RST_EN),
        .BIT_OK (1)
    ) u_en (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .byte_we    (en_byte_we),
        .byte_wdata (sfr_wdata),
        .bit_we     (bit_wr && en_bit_hit),
        .bit_sel    (bit_addr[2:0]),
        .bit_wdata  (bit_wdata),
        .q          (en_reg)
    );

    irqc_sfr8 #(
        .RST    (`IRQC_RST_EN2),
        .BIT_OK (0)
    ) u_en2 (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .byte_we    (en2_byte_we),
        .byte_wdata (sfr_wdata),
        .bit_we     (1'b0),
        .bit_sel    (bit_addr[2:0]),
        .bit_wdata  (bit_wdata),
        .q          (en2_reg)
    );

    irqc_sfr8 #(
        .RST    (`IRQC_RST_LVL),
        .BIT_OK (1)
    ) u_lvl (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .byte_we    (lvl_byte_we),
        .byte_wdata (sfr_wdata),
        .bit_we     (bit_wr && lvl_bit_hit),
        .bit_sel    (bit_addr[2:0]),
        .bit_wdata  (bit_wdata),
        .q          (lvl_reg)
    );

    irqc_sfr8 #(
        .RST    (`IRQC_RST_WDOG),
        .BIT_OK (1)
    ) u_wdog (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .byte_we    (wdog_byte_we),
        .byte_wdata (sfr_wdata),
        .bit_we     (bit_wr && wdog_bit_hit),
        .bit_sel    (bit_addr[2:0]),
        .bit_wdata  (bit_wdata),
        .q          (wdog_reg)
    );

    // per-source enables
    assign src_enable[`IRQC_SRC_PSM]   = en2_reg[`IRQC_E2_PSM_EN];
    assign src_enable[`IRQC_SRC_RTC]   = en2_reg[`IRQC_E2_RTC_EN];
    assign src_enable[`IRQC_SRC_METER] = en2_reg[`IRQC_E2_METER_EN];
    assign src_enable[`IRQC_SRC_WDT]   = 1'b1;
    assign src_enable[`IRQC_SRC_TEMP]  = en_reg[`IRQC_EN_TEMP];
    assign src_enable[`IRQC_SRC_EXT0]  = en_reg[`IRQC_EN_EXT0];
    assign src_enable[`IRQC_SRC_T0]    = en_reg[`IRQC_EN_T0];
    assign src_enable[`IRQC_SRC_EXT1]  = en_reg[`IRQC_EN_EXT1];
    assign src_enable[`IRQC_SRC_T1]    = en_reg[`IRQC_EN_T1];
    assign src_enable[`IRQC_SRC_SPI]   = en2_reg[`IRQC_E2_SPI_EN];
    assign src_enable[`IRQC_SRC_UART]  = en_reg[`IRQC_EN_UART];
    assign src_enable[`IRQC_SRC_T2]    = en_reg[`IRQC_EN_T2];
    assign src_enable[`IRQC_SRC_UART2] = en2_reg[`IRQC_E2_UART2_EN];

    // per-source level, 1 = high
    assign src_high[`IRQC_SRC_PSM]   = 1'b0;
    assign src_high[`IRQC_SRC_RTC]   = en2_reg[`IRQC_E2_RTC_LVL];
    assign src_high[`IRQC_SRC_METER] = lvl_reg[`IRQC_LB_METER];
    assign src_high[`IRQC_SRC_WDT]   = 1'b0;
    assign src_high[`IRQC_SRC_TEMP]  = lvl_reg[`IRQC_LB_TEMP];
    assign src_high[`IRQC_SRC_EXT0]  = lvl_reg[`IRQC_LB_EXT0];
    assign src_high[`IRQC_SRC_T0]    = lvl_reg[`IRQC_LB_T0];
    assign src_high[`IRQC_SRC_EXT1]  = lvl_reg[`IRQC_LB_EXT1];
    assign src_high[`IRQC_SRC_T1]    = lvl_reg[`IRQC_LB_T1];
    assign src_high[`IRQC_SRC_SPI]   = en2_reg[`IRQC_E2_SPI_LVL];
    assign src_high[`IRQC_SRC_UART]  = lvl_reg[`IRQC_LB_UART];
    assign src_high[`IRQC_SRC_T2]    = lvl_reg[`IRQC_LB_T2];
    assign src_high[`IRQC_SRC_UART2] = en2_reg[`IRQC_E2_UART2_LVL];

    // pending, enabled and globally gated
    assign req_all = src_pend & src_enable &
                     {NSRC{en_reg[`IRQC_BIT_GATE]}};

    // split onto three levels
    assign req_lvl[`IRQC_LVL_TOP] =
        req_all & ({{(NSRC-1){1'b0}}, 1'b1} << `IRQC_SRC_PSM);
    assign req_lvl[`IRQC_LVL_HIGH] =
        req_all & src_high & ~req_lvl[`IRQC_LVL_TOP];
    assign req_lvl[`IRQC_LVL_LOW] =
        req_all & ~src_high & ~req_lvl[`IRQC_LVL_TOP];

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_lvl
            irqc_pick #(
                .N (NSRC)
            ) u_pick (
                .req   (req_lvl[g]),
                .found (lvl_found[g]),
                .idx   (lvl_idx[g])
            );
        end
    endgenerate

    // choose highest level that may preempt what is running
    always @* begin
        pick_ok  = 1'b0;
        pick_lvl = `IRQC_LVL_LOW;
        pick_idx = 4'h0;
        if (lvl_found[`IRQC_LVL_TOP] && !active_q[`IRQC_LVL_TOP]) begin
            pick_ok  = 1'b1;
            pick_lvl = `IRQC_LVL_TOP;
            pick_idx = lvl_idx[`IRQC_LVL_TOP];
        end else if (lvl_found[`IRQC_LVL_HIGH] &&
                     (active_q[2:1] == 2'h0)) begin
            pick_ok  = 1'b1;
            pick_lvl = `IRQC_LVL_HIGH;
            pick_idx = lvl_idx[`IRQC_LVL_HIGH];
        end else if (lvl_found[`IRQC_LVL_LOW] &&
                     (active_q == 3'h0)) begin
            pick_ok  = 1'b1;
            pick_lvl = `IRQC_LVL_LOW;
            pick_idx = lvl_idx[`IRQC_LVL_LOW];
        end
    end

    // in-service levels and hold-off
    always @* begin
        active_d = active_q;
        if (irq_ack && req_q) begin
            active_d[lvl_q] = 1'b1;
        end else if (reti) begin
            if (active_q[`IRQC_LVL_TOP]) begin
                active_d[`IRQC_LVL_TOP] = 1'b0;
            end else if (active_q[`IRQC_LVL_HIGH]) begin
                active_d[`IRQC_LVL_HIGH] = 1'b0;
            end else begin
                active_d[`IRQC_LVL_LOW] = 1'b0;
            end
        end
        hold_d = hold_q;
        if (reti || cfg_access) begin
            hold_d = 1'b1;
        end else if (insn_done) begin
            hold_d = 1'b0;
        end
    end

    // request register; a top-level offer is held until taken, others are re-picked every cycle
    always @* begin
        req_d = req_q;
        lvl_d = lvl_q;
        idx_d = idx_q;
        vec_d = vec_q;
        if (irq_ack && req_q) begin
            req_d = 1'b0;
        end else if (!req_q || lvl_q != `IRQC_LVL_TOP) begin
            req_d = pick_ok && !hold_d && !hold_q &&
                    !core_off_mode;
            if (pick_ok) begin
                lvl_d = pick_lvl;
                idx_d = pick_idx;
                vec_d = vec_of(pick_idx);
            end
        end
    end

    // register read back
    always @* begin
        case (sfr_addr)
            `IRQC_ADDR_EN:   rdata_d = en_reg;
            `IRQC_ADDR_EN2:  rdata_d = en2_reg;
            `IRQC_ADDR_LVL:  rdata_d = lvl_reg;
            `IRQC_ADDR_WDOG: rdata_d = wdog_reg;
            default:         rdata_d = 8'h00;
        endcase
        if (en_bit_hit) begin
            bdata_d = en_reg[bit_addr[2:0]];
        end else if (lvl_bit_hit) begin
            bdata_d = lvl_reg[bit_addr[2:0]];
        end else if (wdog_bit_hit) begin
            bdata_d = wdog_reg[bit_addr[2:0]];
        end else begin
            bdata_d = 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            active_q  <= 3'h0;
            hold_q    <= 1'b0;
            req_q     <= 1'b0;
            lvl_q     <= `IRQC_LVL_LOW;
            idx_q     <= 4'h0;
            vec_q     <= `IRQC_VEC_BASE;
            sfr_rdata <= 8'h00;
            bit_rdata <= 1'b0;
        end else if (ce) begin
            active_q  <= active_d;
            hold_q    <= hold_d;
            req_q     <= req_d;
            lvl_q     <= lvl_d;
            idx_q     <= idx_d;
            vec_q     <= vec_d;
            if (sfr_rd) begin
                sfr_rdata <= rdata_d;
            end
            if (bit_rd) begin
                bit_rdata <= bdata_d;
            end
        end
    end

    // outputs
    always @* begin
        irq_req    = req_q;
        irq_vector = vec_q;
        irq_src    = idx_q;
        irq_active = active_q;
    end
endmodule // irqc_top

// File: irqc_consts.vh
`ifndef IRQC_CONSTS_VH
`define IRQC_CONSTS_VH

`define IRQC_ADDR_EN      8'ha8
`define IRQC_ADDR_EN2     8'ha9
`define IRQC_ADDR_LVL     8'hb8
`define IRQC_ADDR_WDOG    8'hc0

`define IRQC_RST_EN       8'h00
`define IRQC_RST_EN2      8'ha0
`define IRQC_RST_LVL      8'h00
`define IRQC_RST_WDOG     8'h10

`define IRQC_BIT_GATE     7

// enable register bits
`define IRQC_EN_TEMP      6
`define IRQC_EN_T2        5
`define IRQC_EN_UART      4
`define IRQC_EN_T1        3
`define IRQC_EN_EXT1      2
`define IRQC_EN_T0        1
`define IRQC_EN_EXT0      0

// level register bits
`define IRQC_LB_METER     7
`define IRQC_LB_TEMP      6
`define IRQC_LB_T2        5
`define IRQC_LB_UART      4
`define IRQC_LB_T1        3
`define IRQC_LB_EXT1      2
`define IRQC_LB_T0        1
`define IRQC_LB_EXT0      0

// second register bits
`define IRQC_E2_UART2_LVL 7
`define IRQC_E2_RTC_LVL   6
`define IRQC_E2_UART2_EN  5
`define IRQC_E2_SPI_LVL   4
`define IRQC_E2_METER_EN  3
`define IRQC_E2_RTC_EN    2
`define IRQC_E2_PSM_EN    1
`define IRQC_E2_SPI_EN    0

`define IRQC_NSRC         13
`define IRQC_SRC_PSM      0
`define IRQC_SRC_RTC      1
`define IRQC_SRC_METER    2
`define IRQC_SRC_WDT      3
`define IRQC_SRC_TEMP     4
`define IRQC_SRC_EXT0     5
`define IRQC_SRC_T0       6
`define IRQC_SRC_EXT1     7
`define IRQC_SRC_T1       8
`define IRQC_SRC_SPI      9
`define IRQC_SRC_UART     10
`define IRQC_SRC_T2       11
`define IRQC_SRC_UART2    12

`define IRQC_LVL_LOW      2'h0
`define IRQC_LVL_HIGH     2'h1
`define IRQC_LVL_TOP      2'h2

`define IRQC_VEC_BASE     16'h0003
`define IRQC_VEC_STEP     16'h0008

`endif

// File: irqc_pick.v
`timescale 1ns/10ps
// fixed polling order: lowest index wins
module irqc_pick #(
    parameter N = 13
) (
    // request mask
    input  wire [N-1:0] req,
    // winner
    output reg          found,
    output reg  [3:0]   idx
);
    integer i;

    always @* begin
        found = 1'b0;
        idx   = 4'h0;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = i[3:0];
            end
        end
    end
endmodule // irqc_pick

// File: irqc_sfr8.v
`timescale 1ns/10ps
// one 8-bit special function register with optional bit access
module irqc_sfr8 #(
    parameter [7:0] RST    = 8'h00,
    parameter       BIT_OK = 1
) (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       ce,
    // byte write
    input  wire       byte_we,
    input  wire [7:0] byte_wdata,
    // bit write
    input  wire       bit_we,
    input  wire [2:0] bit_sel,
    input  wire       bit_wdata,
    // contents
    output wire [7:0] q
);
    reg [7:0] val_q;
    reg [7:0] val_d;

    assign q = val_q;

    always @* begin
        val_d = val_q;
        if (byte_we) begin
            val_d = byte_wdata;
        end else if (bit_we && (BIT_OK != 0)) begin
            val_d[bit_sel] = bit_wdata;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            val_q <= RST;
        end else if (ce) begin
            val_q <= val_d;
        end
    end
endmodule // irqc_sfr8

// File: irqc_sva.sv
`timescale 1ns/10ps
// watches dispatch, hold-off and read data of the controller
module irqc_sva #(
    parameter NSRC = 13
) (
    // clock and reset
    input wire logic            ref_clk,
    input wire logic            rst_n,
    input wire logic            ce,
    // register side
    input wire logic [7:0]      sfr_addr,
    input wire logic            sfr_wr,
    input wire logic            sfr_rd,
    input wire logic [7:0]      sfr_rdata,
    // sources and core
    input wire logic [NSRC-1:0] src_pend,
    input wire logic            core_off_mode,
    input wire logic            reti,
    input wire logic            irq_ack,
    // dispatch
    input wire logic            irq_req,
    input wire logic [15:0]     irq_vector,
    input wire logic [3:0]      irq_src,
    input wire logic [2:0]      irq_active
);
    // vector slot of each polling index
    localparam logic [3:0] RANK [0:12] = '{4'h8, 4'ha, 4'h9, 4'hb, 4'h6,
        4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h4, 4'h5, 4'hc};
    logic [NSRC-1:0] pend_q;
    logic            ctl_acc;

    always @(posedge ref_clk) begin
        pend_q <= src_pend;
    end
    assign ctl_acc = ce && (sfr_wr || sfr_rd) && (sfr_addr == 8'ha8 ||
                     sfr_addr == 8'ha9 || sfr_addr == 8'hb8);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    AST_PEND_HELD: assert property (irq_req |-> pend_q[irq_src])
        else $error("offer without a pending source");
    AST_VECTOR: assert property (irq_req |->
        irq_vector == 16'h0003 + {9'h000, RANK[irq_src], 3'h0})
        else $error("vector does not match source");
    AST_CORE_OFF: assert property (
        $past(core_off_mode) && !$past(irq_req) |-> !irq_req)
        else $error("offer while core is off");
    AST_RETI_HOLD: assert property (ce && reti |-> ##1 !irq_req [*2])
        else $error("offer too soon after return");
    AST_ACCESS_HOLD: assert property (ctl_acc |-> ##1 !irq_req [*2])
        else $error("offer too soon after register access");
    AST_ACK_DROP: assert property (irq_req && irq_ack |=> !irq_req)
        else $error("offer stands after acknowledge");
    AST_ACK_TOP: assert property (
        irq_req && irq_ack && irq_src == 4'h0 |=> irq_active[2])
        else $error("power monitor service not marked on top level");
    AST_ACTIVE_RISE: assert property (
        (irq_active & ~$past(irq_active)) != 3'h0 |-> $past(irq_req && irq_ack))
        else $error("service level set without acknowledge");
    AST_ACTIVE_FALL: assert property (
        ($past(irq_active) & ~irq_active) != 3'h0 |-> $past(reti))
        else $error("service level cleared without return");
    AST_TOP_BLOCK: assert property (irq_active[2] |-> !irq_req)
        else $error("offer during top level service");
    AST_RDATA_STANDS: assert property (
        !$past(sfr_rd) |-> $stable(sfr_rdata))
        else $error("read data changed without read");
endmodule // irqc_sva

bind irqc_top irqc_sva #(.NSRC(NSRC)) i_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .src_pend(src_pend), .core_off_mode(core_off_mode), .reti(reti),
    .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_src(irq_src), .irq_active(irq_active)
);

// File: irqc_core_model.sv
`timescale 1ns/10ps
// core side: retires an instruction every third cycle, takes every offer
module irqc_core_model (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // commands and offer
    input  wire logic reti_go,
    input  wire logic irq_req,
    // core status
    output logic      insn_done,
    output logic      reti,
    output logic      irq_ack
);
    logic [1:0] cnt_q;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q <= 2'h0;
            insn_done <= 1'b0;
            reti <= 1'b0;
            irq_ack <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
            insn_done <= (cnt_q == 2'h2);
            reti <= reti_go & ~reti;
            irq_ack <= irq_req & ~irq_ack;
        end
    end
endmodule // irqc_core_model

// File: three_level_irq_controller_tb.sv
`timescale 1ns/10ps
module three_level_irq_controller_tb;
    localparam logic [3:0] RANK [0:12] = '{4'h8, 4'ha, 4'h9, 4'hb, 4'h6,
        4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h4, 4'h5, 4'hc};
    // level bit per source: bit3 second register, bits 2..0 position
    localparam logic [3:0] LVL [0:12] = '{4'h0, 4'he, 4'h7, 4'h0, 4'h6,
        4'h0, 4'h1, 4'h2, 4'h3, 4'hc, 4'h4, 4'h5, 4'hf};
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  bit_addr = 8'h00;
    logic        bit_wr = 1'b0;
    logic        bit_rd = 1'b0;
    logic        bit_wdata = 1'b0;
    logic [12:0] src_pend = 13'h0000;
    logic        core_off_mode = 1'b0;
    logic        reti_go = 1'b0;
    wire  [7:0]  sfr_rdata;
    wire         bit_rdata;
    wire         insn_done;
    wire         reti;
    wire         irq_ack;
    wire         irq_req;
    wire  [15:0] irq_vector;
    wire  [3:0]  irq_src;
    wire  [2:0]  irq_active;
    int          n_fail = 0;
    int          samples_checked = 0;

    always #2 ref_clk = ~ref_clk;

    irqc_top #(.NSRC(13)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr),
        .bit_rd(bit_rd), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata),
        .src_pend(src_pend), .core_off_mode(core_off_mode),
        .insn_done(insn_done), .reti(reti), .irq_ack(irq_ack),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_src(irq_src),
        .irq_active(irq_active)
    );

    irqc_core_model i_core (
        .ref_clk(ref_clk), .rst_n(rst_n), .reti_go(reti_go),
        .irq_req(irq_req), .insn_done(insn_done), .reti(reti),
        .irq_ack(irq_ack)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(sfr_rdata, exp);
    endtask

    task automatic bwr(input logic [7:0] a, input logic v);
        @(posedge ref_clk);
        bit_addr <= a;
        bit_wdata <= v;
        bit_wr <= 1'b1;
        @(posedge ref_clk);
        bit_wr <= 1'b0;
    endtask

    task automatic brdc(input logic [7:0] a, input logic exp);
        @(posedge ref_clk);
        bit_addr <= a;
        bit_rd <= 1'b1;
        @(posedge ref_clk);
        bit_rd <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(bit_rdata, exp);
    endtask

    // wait for an offer, check it, let the core take it
    task automatic take(input logic [3:0] s, input logic [2:0] act);
        #1;
        repeat (60) if (irq_req !== 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
        chk(irq_req, 1'b1);
        chk(irq_src, s);
        chk(irq_vector, 16'h0003 + {9'h000, RANK[s], 3'h0});
        repeat (3) @(posedge ref_clk);
        #1;
        chk(irq_active, act);
        @(posedge ref_clk);
    endtask

    task automatic no_req(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            chk(irq_req, 1'b0);
        end
        @(posedge ref_clk);
    endtask

    task automatic reti_chk(input logic [2:0] act);
        @(posedge ref_clk);
        reti_go <= 1'b1;
        @(posedge ref_clk);
        reti_go <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(irq_active, act);
        @(posedge ref_clk);
    endtask

    task automatic t_reset;
        rdc(8'ha8, 8'h00);
        rdc(8'ha9, 8'ha0);
        rdc(8'hb8, 8'h00);
        rdc(8'hc0, 8'h10);
        rdc(8'h00, 8'h00);
        chk(irq_active, 3'h0);
    endtask

    task automatic t_bits;
        bwr(8'haf, 1'b1);
        rdc(8'ha8, 8'h80);
        bwr(8'hbc, 1'b1);
        brdc(8'hbc, 1'b1);
        rdc(8'hb8, 8'h10);
        bwr(8'ha9, 1'b1);
        rdc(8'ha9, 8'ha0);
        rdc(8'ha8, 8'h82);
        wr(8'hb8, 8'h00);
        ce <= 1'b0;
        wr(8'ha8, 8'h00);
        ce <= 1'b1;
        rdc(8'ha8, 8'h82);
    endtask

    task automatic t_order;
        wr(8'ha8, 8'hff);
        wr(8'ha9, 8'h2f);
        for (int i = 0; i < 13; i++) begin
            src_pend <= 13'h1fff << i;
            take(i[3:0], (i == 0) ? 3'h4 : 3'h1);
            src_pend <= 13'h0000;
            reti_chk(3'h0);
        end
    endtask

    task automatic t_gate;
        wr(8'ha8, 8'h7f);
        src_pend <= 13'h1fff;
        no_req(20);
        wr(8'ha8, 8'h80);
        wr(8'ha9, 8'h00);
        src_pend <= 13'h1ff7;
        no_req(20);
        src_pend <= 13'h0008;
        take(4'h3, 3'h1);
        src_pend <= 13'h0000;
        reti_chk(3'h0);
        wr(8'ha8, 8'hff);
        wr(8'ha9, 8'h2f);
        core_off_mode <= 1'b1;
        src_pend <= 13'h1fff;
        no_req(20);
        core_off_mode <= 1'b0;
        take(4'h0, 3'h4);
        src_pend <= 13'h0000;
        reti_chk(3'h0);
    endtask

    task automatic t_level;
        for (int i = 1; i < 13; i++) begin
            if (i != 3) begin
                wr(8'hb8, LVL[i][3] ? 8'h00 : 8'h01 << LVL[i][2:0]);
                wr(8'ha9, LVL[i][3] ? 8'h2f | 8'h01 << LVL[i][2:0] : 8'h2f);
                src_pend <= 13'h1ffe;
                take(i[3:0], 3'h2);
                src_pend <= 13'h0000;
                reti_chk(3'h0);
            end
        end
        wr(8'hb8, 8'h00);
    endtask

    task automatic t_preempt;
        wr(8'ha9, 8'haf);
        wr(8'hb8, 8'h08);
        src_pend <= 13'h0020;
        take(4'h5, 3'h1);
        src_pend <= 13'h0060;
        no_req(20);
        src_pend <= 13'h1060;
        take(4'hc, 3'h3);
        src_pend <= 13'h1160;
        no_req(20);
        src_pend <= 13'h1161;
        take(4'h0, 3'h7);
        src_pend <= 13'h0000;
        reti_chk(3'h3);
        reti_chk(3'h1);
        reti_chk(3'h0);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_bits();
        t_order();
        t_gate();
        t_level();
        t_preempt();
        print_verdict();
    end
endmodule // three_level_irq_controller_tb
